/* File: logic/ppm_top.sv */
// Function
// [RULE1] Each first-port pin is input or output by its own direction bit.
// [RULE2] First-port input pins get a pull-up only when their pull-up bit is set.
// [RULE3] First-port alternates: irq a, irq b, remote timer, converter 0-3, buzzer.
// [RULE4] Each external interrupt input detects rising, falling or both edges.
// [RULE5] Each second-port pin is input or output by its own direction bit.
// [RULE6] Second-port input pins get a pull-up only when their pull-up bit is set.
// [RULE7] Second-port alternates: serial b clock/data, converter 4-6, serial a.
// [RULE8] Third port is output only; alternate mode carries display outputs 24-31.
// [RULE9] Ports three to six drive only high, otherwise they are released.
// [RULE10] Fourth port is output only; alternate mode carries display outputs 32-39.
// [RULE11] Fifth port is input/output; alternate mode carries display outputs 40-47.
// [RULE12] Sixth port is 5-bit; display 48-52, event counter on 3, pwm on 4.
// [RULE13] Port or alternate mode is selected separately for every single pin.
// [RULE14] Reset is active while low; the outside drives it low.
// [RULE15] Display outputs 0-23 are dedicated pins without port function.
// [RULE16] Alternate mode: peripheral output and enable override; inputs still routed.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "ppm_consts.svh"
module ppm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire ppm_pkg::ppm_byte_t first_port_in,
  output ppm_pkg::ppm_byte_t first_port_out,
  output ppm_pkg::ppm_byte_t first_port_oe_n,
  output ppm_pkg::ppm_byte_t first_port_pullup,
  input wire ppm_pkg::ppm_byte_t second_port_in,
  output ppm_pkg::ppm_byte_t second_port_out,
  output ppm_pkg::ppm_byte_t second_port_oe_n,
  output ppm_pkg::ppm_byte_t second_port_pullup,
  output ppm_pkg::ppm_byte_t third_port_out,
  output ppm_pkg::ppm_byte_t third_port_oe_n,
  output ppm_pkg::ppm_byte_t fourth_port_out,
  output ppm_pkg::ppm_byte_t fourth_port_oe_n,
  input wire ppm_pkg::ppm_byte_t fifth_port_in,
  output ppm_pkg::ppm_byte_t fifth_port_out,
  output ppm_pkg::ppm_byte_t fifth_port_oe_n,
  input wire logic [4:0] sixth_port_in,
  output logic [4:0] sixth_port_out,
  output logic [4:0] sixth_port_oe_n,
  output logic [23:0] display_seg_pin,
  input wire logic [52:0] display_seg_out,
  input wire logic buzzer_out,
  input wire logic serial_b_clock_out,
  input wire logic serial_b_clock_oe,
  input wire logic serial_b_data_out,
  input wire logic serial_a_data_out,
  input wire logic serial_a_clock_out,
  input wire logic serial_a_clock_oe,
  input wire logic pwm_out,
  output logic remote_timer_in,
  output logic [6:0] conv_channel,
  output logic serial_b_clock_in,
  output logic serial_a_data_in,
  output logic serial_a_clock_in,
  output logic event_counter_in
);
  import ppm_pkg::*;

  ppm_top_s s;
  ppm_top_s next_s;
  logic pulse_a;
  logic pulse_b;
  ppm_byte_t p3_oe_n;
  ppm_byte_t p4_oe_n;
  ppm_byte_t p5_oe_n;
  ppm_byte_t p5_in_q;
  ppm_byte_t p6_oe_n;
  ppm_byte_t p6_in_q;
  ppm_byte_t p6_seg;

  // External interrupt edge detectors on first-port bits 0 and 1
  ppm_edge_det u_edge_a (
    .pclk(pclk),
    .presetn(presetn),
    .level(first_port_in[0]),
    .enable(s.fp_alt[0]),
    .mode(s.mode_a),
    .pulse(pulse_a)
  );

  ppm_edge_det u_edge_b (
    .pclk(pclk),
    .presetn(presetn),
    .level(first_port_in[1]),
    .enable(s.fp_alt[1]),
    .mode(s.mode_b),
    .pulse(pulse_b)
  );

  // Pin 4 of the sixth port carries pwm or display segment 52
  assign p6_seg = {3'h0, s.pwm_sel ? pwm_out : display_seg_out[52],
                   display_seg_out[51:48]}; // RULE12

  // Open-drain ports three to six
  ppm_od_port u_port3 (
    .pclk(pclk),
    .presetn(presetn),
    .data(s.p3_data),
    .alt(s.p3_alt),
    .seg(display_seg_out[31:24]),
    .pin_in(`PPM_RST_BYTE),
    .oe_n(p3_oe_n),
    .in_q()
  );

  ppm_od_port u_port4 (
    .pclk(pclk),
    .presetn(presetn),
    .data(s.p4_data),
    .alt(s.p4_alt),
    .seg(display_seg_out[39:32]),
    .pin_in(`PPM_RST_BYTE),
    .oe_n(p4_oe_n),
    .in_q()
  );

  ppm_od_port u_port5 (
    .pclk(pclk),
    .presetn(presetn),
    .data(s.p5_data),
    .alt(s.p5_alt),
    .seg(display_seg_out[47:40]),
    .pin_in(fifth_port_in),
    .oe_n(p5_oe_n),
    .in_q(p5_in_q)
  );

  ppm_od_port u_port6 (
    .pclk(pclk),
    .presetn(presetn),
    .data({3'h0, s.p6_data}),
    .alt({3'h0, s.p6_alt}),
    .seg(p6_seg),
    .pin_in({3'h0, sixth_port_in}),
    .oe_n(p6_oe_n),
    .in_q(p6_in_q)
  );

  // Register access, interrupts and pin multiplexing
  always_comb begin
    logic access;
    logic hit;
    logic [1:0] w1c;
    ppm_byte_t fp_drive;
    ppm_byte_t sp_drive;
    ppm_byte_t sp_per;
    ppm_byte_t wb;
    access = psel & penable & ~s.pready;
    hit = 1'b1;
    w1c = 2'b00;
    fp_drive = 8'h00;
    sp_drive = 8'h00;
    sp_per = 8'h00;
    wb = pwdata[7:0];
    next_s = s;
    next_s.pready = access;
    next_s.pslverr = 1'b0;
    next_s.drive_hi = 1'b1;

    // Address decode, writes and read data
    if (access) begin
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        `PPM_OFS_FP_DATA: begin
          if (pwrite) next_s.fp_data = wb;
          next_s.prdata[7:0] = s.fp_data;
        end
        `PPM_OFS_FP_DIR: begin
          if (pwrite) next_s.first_port_direction = wb; // RULE1
          next_s.prdata[7:0] = s.first_port_direction;
        end
        `PPM_OFS_FP_PULL: begin
          if (pwrite) next_s.first_port_pullup_enable = wb;
          next_s.prdata[7:0] = s.first_port_pullup_enable;
        end
        `PPM_OFS_FP_ALT: begin
          if (pwrite) next_s.fp_alt = wb; // RULE13
          next_s.prdata[7:0] = s.fp_alt;
        end
        `PPM_OFS_SP_DATA: begin
          if (pwrite) next_s.sp_data = wb;
          next_s.prdata[7:0] = s.sp_data;
        end
        `PPM_OFS_SP_DIR: begin
          if (pwrite) next_s.second_port_direction = wb; // RULE5
          next_s.prdata[7:0] = s.second_port_direction;
        end
        `PPM_OFS_SP_PULL: begin
          if (pwrite) next_s.second_port_pullup_enable = wb;
          next_s.prdata[7:0] = s.second_port_pullup_enable;
        end
        `PPM_OFS_SP_ALT: begin
          if (pwrite) next_s.sp_alt = wb; // RULE13
          next_s.prdata[7:0] = s.sp_alt;
        end
        `PPM_OFS_P3_DATA: begin
          if (pwrite) next_s.p3_data = wb;
          next_s.prdata[7:0] = s.p3_data;
        end
        `PPM_OFS_P3_ALT: begin
          if (pwrite) next_s.p3_alt = wb; // RULE13
          next_s.prdata[7:0] = s.p3_alt;
        end
        `PPM_OFS_P4_DATA: begin
          if (pwrite) next_s.p4_data = wb;
          next_s.prdata[7:0] = s.p4_data;
        end
        `PPM_OFS_P4_ALT: begin
          if (pwrite) next_s.p4_alt = wb; // RULE13
          next_s.prdata[7:0] = s.p4_alt;
        end
        `PPM_OFS_P5_DATA: begin
          if (pwrite) next_s.p5_data = wb;
          next_s.prdata[7:0] = s.p5_data;
        end
        `PPM_OFS_P5_ALT: begin
          if (pwrite) next_s.p5_alt = wb; // RULE13
          next_s.prdata[7:0] = s.p5_alt;
        end
        `PPM_OFS_P6_DATA: begin
          if (pwrite) next_s.p6_data = wb[4:0];
          next_s.prdata[4:0] = s.p6_data;
        end
        `PPM_OFS_P6_ALT: begin
          if (pwrite) next_s.p6_alt = wb[4:0]; // RULE13
          next_s.prdata[4:0] = s.p6_alt;
        end
        `PPM_OFS_PIN_LEVEL: begin
          next_s.prdata[28:0] = {p6_in_q[4:0], p5_in_q, s.sp_in_q, s.fp_in_q};
        end
        `PPM_OFS_EDGE_CFG: begin
          if (pwrite) begin
            next_s.mode_a = ppm_edge_e'(pwdata[`PPM_EDGE_A_LSB +: 2]); // RULE4
            next_s.mode_b = ppm_edge_e'(pwdata[`PPM_EDGE_B_LSB +: 2]); // RULE4
            next_s.pwm_sel = pwdata[`PPM_PWM_SEL_BIT];
          end
          next_s.prdata[`PPM_EDGE_A_LSB +: 2] = s.mode_a;
          next_s.prdata[`PPM_EDGE_B_LSB +: 2] = s.mode_b;
          next_s.prdata[`PPM_PWM_SEL_BIT] = s.pwm_sel;
        end
        `PPM_OFS_IRQ_STATUS: begin
          if (pwrite) w1c = pwdata[1:0];
          next_s.prdata[1:0] = s.irq_status;
        end
        `PPM_OFS_IRQ_MASK: begin
          if (pwrite) next_s.irq_mask = pwdata[1:0];
          next_s.prdata[1:0] = s.irq_mask;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      next_s.pslverr = ~hit;
    end

    // Sticky status, new edge wins over a clear in the same cycle
    next_s.irq_status = (s.irq_status & ~w1c) | {pulse_b, pulse_a}; // RULE4
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);

    // First port pad: alternate output overrides data and direction
    fp_drive = ppm_mux(s.fp_alt, s.first_port_direction, `PPM_FP_ALT_DRIVE); // RULE16
    next_s.fp_out = ppm_mux(s.fp_alt, s.fp_data, {buzzer_out, 7'h00}); // RULE3
    next_s.fp_oe_n = ~fp_drive; // RULE1
    next_s.fp_pu = s.first_port_pullup_enable & ~fp_drive; // RULE2
    next_s.fp_in_q = first_port_in;

    // Second port pad: serial drivers override in alternate mode
    sp_per = {serial_a_clock_out, 1'b0, serial_a_data_out, 3'h0,
              serial_b_data_out, serial_b_clock_out}; // RULE7
    sp_drive = ppm_mux(s.sp_alt, s.second_port_direction,
                       {serial_a_clock_oe, 1'b0, 1'b1, 3'h0, 1'b1,
                        serial_b_clock_oe}); // RULE16
    next_s.sp_out = ppm_mux(s.sp_alt, s.sp_data, sp_per); // RULE7
    next_s.sp_oe_n = ~sp_drive; // RULE5
    next_s.sp_pu = s.second_port_pullup_enable & ~sp_drive; // RULE6
    next_s.sp_in_q = second_port_in;

    // Inputs routed to the peripherals whatever the pin mode
    next_s.remote_timer_in = first_port_in[2]; // RULE3
    next_s.conv_channel = {second_port_in[4:2], first_port_in[6:3]}; // RULE7
    next_s.serial_b_clock_in = second_port_in[0]; // RULE7
    next_s.serial_a_data_in = second_port_in[6]; // RULE7
    next_s.serial_a_clock_in = second_port_in[7]; // RULE16
    next_s.event_counter_in = sixth_port_in[3]; // RULE12

    // Dedicated display outputs
    next_s.seg_dedicated = display_seg_out[23:0]; // RULE15
  end

  // State register, reset while presetn is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin // RULE14
      s <= '0;
      s.fp_oe_n <= `PPM_RST_OE_N;
      s.sp_oe_n <= `PPM_RST_OE_N;
      s.mode_a <= ppm_edge_e'(`PPM_RST_EDGE);
      s.mode_b <= ppm_edge_e'(`PPM_RST_EDGE);
    end else begin
      s <= next_s;
    end
  end

  // Bus and interrupt outputs
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;

  // Bidirectional port pads
  assign first_port_out = s.fp_out;
  assign first_port_oe_n = s.fp_oe_n;
  assign first_port_pullup = s.fp_pu;
  assign second_port_out = s.sp_out;
  assign second_port_oe_n = s.sp_oe_n;
  assign second_port_pullup = s.sp_pu;

  // Open-drain pads drive high only
  assign third_port_out = {8{s.drive_hi}}; // RULE9
  assign third_port_oe_n = p3_oe_n; // RULE8
  assign fourth_port_out = {8{s.drive_hi}}; // RULE9
  assign fourth_port_oe_n = p4_oe_n; // RULE10
  assign fifth_port_out = {8{s.drive_hi}}; // RULE9
  assign fifth_port_oe_n = p5_oe_n; // RULE11
  assign sixth_port_out = {5{s.drive_hi}}; // RULE9
  assign sixth_port_oe_n = p6_oe_n[4:0]; // RULE12

  // Peripheral-facing outputs
  assign display_seg_pin = s.seg_dedicated;
  assign remote_timer_in = s.remote_timer_in;
  assign conv_channel = s.conv_channel;
  assign serial_b_clock_in = s.serial_b_clock_in;
  assign serial_a_data_in = s.serial_a_data_in;
  assign serial_a_clock_in = s.serial_a_clock_in;
  assign event_counter_in = s.event_counter_in;
endmodule

/* File: logic/ppm_consts.svh */
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

// Register byte offsets
`define PPM_OFS_FP_DATA 8'h00
`define PPM_OFS_FP_DIR 8'h04
`define PPM_OFS_FP_PULL 8'h08
`define PPM_OFS_FP_ALT 8'h0c
`define PPM_OFS_SP_DATA 8'h10
`define PPM_OFS_SP_DIR 8'h14
`define PPM_OFS_SP_PULL 8'h18
`define PPM_OFS_SP_ALT 8'h1c
`define PPM_OFS_P3_DATA 8'h20
`define PPM_OFS_P3_ALT 8'h24
`define PPM_OFS_P4_DATA 8'h28
`define PPM_OFS_P4_ALT 8'h2c
`define PPM_OFS_P5_DATA 8'h30
`define PPM_OFS_P5_ALT 8'h34
`define PPM_OFS_P6_DATA 8'h38
`define PPM_OFS_P6_ALT 8'h3c
`define PPM_OFS_PIN_LEVEL 8'h40
`define PPM_OFS_EDGE_CFG 8'h44
`define PPM_OFS_IRQ_STATUS 8'h48
`define PPM_OFS_IRQ_MASK 8'h4c

// Field positions in the edge configuration register
`define PPM_EDGE_A_LSB 0
`define PPM_EDGE_B_LSB 2
`define PPM_PWM_SEL_BIT 4

// Reset values
`define PPM_RST_BYTE 8'h00
`define PPM_RST_OE_N 8'hff
`define PPM_RST_EDGE 2'b00

// First port: pins that the alternate function drives
`define PPM_FP_ALT_DRIVE 8'h80

`endif

/* File: logic/ppm_pkg.sv */
package ppm_pkg;

  typedef logic [7:0] ppm_byte_t;

  // Valid edge selection of an external interrupt input
  typedef enum logic [1:0] {
    ppm_edge_rise = 2'b00,
    ppm_edge_fall = 2'b01,
    ppm_edge_both = 2'b10,
    ppm_edge_off = 2'b11
  } ppm_edge_e;

  typedef struct packed {
    logic prev;
    logic pulse;
  } ppm_edge_s;

  typedef struct packed {
    ppm_byte_t oe_n;
    ppm_byte_t in_q;
  } ppm_od_s;

  typedef struct packed {
    ppm_byte_t fp_data;
    ppm_byte_t first_port_direction;
    ppm_byte_t first_port_pullup_enable;
    ppm_byte_t fp_alt;
    ppm_byte_t sp_data;
    ppm_byte_t second_port_direction;
    ppm_byte_t second_port_pullup_enable;
    ppm_byte_t sp_alt;
    ppm_byte_t p3_data;
    ppm_byte_t p3_alt;
    ppm_byte_t p4_data;
    ppm_byte_t p4_alt;
    ppm_byte_t p5_data;
    ppm_byte_t p5_alt;
    logic [4:0] p6_data;
    logic [4:0] p6_alt;
    ppm_edge_e mode_a;
    ppm_edge_e mode_b;
    logic pwm_sel;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    ppm_byte_t fp_out;
    ppm_byte_t fp_oe_n;
    ppm_byte_t fp_pu;
    ppm_byte_t fp_in_q;
    ppm_byte_t sp_out;
    ppm_byte_t sp_oe_n;
    ppm_byte_t sp_pu;
    ppm_byte_t sp_in_q;
    logic drive_hi;
    logic [23:0] seg_dedicated;
    logic remote_timer_in;
    logic [6:0] conv_channel;
    logic serial_b_clock_in;
    logic serial_a_data_in;
    logic serial_a_clock_in;
    logic event_counter_in;
  } ppm_top_s;

  // Per-bit choice between port value and alternate function value
  function automatic ppm_byte_t ppm_mux(input ppm_byte_t alt, input ppm_byte_t port_v,
                                        input ppm_byte_t per_v);
    return (alt & per_v) | (~alt & port_v);
  endfunction

endpackage

/* File: logic/ppm_edge_det.sv */
`timescale 1ns/10ps
module ppm_edge_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  input wire logic enable,
  input wire ppm_pkg::ppm_edge_e mode,
  output logic pulse
);
  import ppm_pkg::*;

  ppm_edge_s s;
  ppm_edge_s next_s;

  // Edge selection per mode
  always_comb begin
    logic rise;
    logic fall;
    rise = level & ~s.prev;
    fall = ~level & s.prev;
    next_s.prev = level;
    unique case (mode)
      ppm_edge_rise: next_s.pulse = enable & rise;
      ppm_edge_fall: next_s.pulse = enable & fall;
      ppm_edge_both: next_s.pulse = enable & (rise | fall);
      ppm_edge_off: next_s.pulse = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.pulse;
endmodule

/* File: logic/ppm_od_port.sv */
`timescale 1ns/10ps
module ppm_od_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire ppm_pkg::ppm_byte_t data,
  input wire ppm_pkg::ppm_byte_t alt,
  input wire ppm_pkg::ppm_byte_t seg,
  input wire ppm_pkg::ppm_byte_t pin_in,
  output ppm_pkg::ppm_byte_t oe_n,
  output ppm_pkg::ppm_byte_t in_q
);
  import ppm_pkg::*;

  ppm_od_s s;
  ppm_od_s next_s;

  // P-channel pin: drives high on a one, released on a zero
  always_comb begin
    next_s.oe_n = ~ppm_mux(alt, data, seg);
    next_s.in_q = pin_in;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.oe_n <= `PPM_RST_OE_N;
      s.in_q <= `PPM_RST_BYTE;
    end else begin
      s <= next_s;
    end
  end

  assign oe_n = s.oe_n;
  assign in_q = s.in_q;
endmodule

/* File: dv/ppm_chk_sva.sv */
`timescale 1ns/10ps
module ppm_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire ppm_pkg::ppm_byte_t first_port_in,
  input wire ppm_pkg::ppm_byte_t first_port_oe_n,
  input wire ppm_pkg::ppm_byte_t first_port_pullup,
  input wire ppm_pkg::ppm_byte_t second_port_in,
  input wire ppm_pkg::ppm_byte_t second_port_oe_n,
  input wire ppm_pkg::ppm_byte_t second_port_pullup,
  input wire ppm_pkg::ppm_byte_t third_port_out,
  input wire ppm_pkg::ppm_byte_t fourth_port_out,
  input wire ppm_pkg::ppm_byte_t fifth_port_out,
  input wire logic [4:0] sixth_port_in,
  input wire logic [4:0] sixth_port_out,
  input wire logic [23:0] display_seg_pin,
  input wire logic [52:0] display_seg_out,
  input wire logic remote_timer_in,
  input wire logic [6:0] conv_channel,
  input wire logic serial_b_clock_in,
  input wire logic serial_a_data_in,
  input wire logic serial_a_clock_in,
  input wire logic event_counter_in
);
  import ppm_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Setup then first access cycle
  sequence s_access;
    psel && !penable ##1 psel && penable && !pready;
  endsequence

  // Answer pulse one cycle after capture
  a_apb_answer: assert property (s_access |=> pready ##1 !pready)
    else $error("bus access not answered as a single pulse");
  a_seg_copy: assert property ($past(presetn) |-> display_seg_pin == $past(display_seg_out[23:0]))
    else $error("dedicated display pins do not follow controller");
  a_timer_route: assert property ($past(presetn) |-> remote_timer_in == $past(first_port_in[2]))
    else $error("remote timer input not routed");
  a_conv_route: assert property ($past(presetn) |->
    conv_channel == $past({second_port_in[4:2], first_port_in[6:3]}))
    else $error("converter channels not routed");
  a_serial_route: assert property ($past(presetn) |->
    serial_b_clock_in == $past(second_port_in[0])
    && serial_a_data_in == $past(second_port_in[6])
    && serial_a_clock_in == $past(second_port_in[7]))
    else $error("serial inputs not routed");
  a_event_route: assert property ($past(presetn) |-> event_counter_in == $past(sixth_port_in[3]))
    else $error("event counter input not routed");
  a_od_high: assert property ($past(presetn) |->
    &{third_port_out, fourth_port_out, fifth_port_out, sixth_port_out})
    else $error("open drain port drives low");
  a_fp_pullup: assert property ((first_port_pullup & ~first_port_oe_n) == 8'h00)
    else $error("first port pull-up on a driven pin");
  a_sp_pullup: assert property ((second_port_pullup & ~second_port_oe_n) == 8'h00)
    else $error("second port pull-up on a driven pin");
endmodule

bind ppm_top ppm_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .first_port_in(first_port_in), .first_port_oe_n(first_port_oe_n),
  .first_port_pullup(first_port_pullup), .second_port_in(second_port_in),
  .second_port_oe_n(second_port_oe_n), .second_port_pullup(second_port_pullup),
  .third_port_out(third_port_out), .fourth_port_out(fourth_port_out),
  .fifth_port_out(fifth_port_out), .sixth_port_in(sixth_port_in),
  .sixth_port_out(sixth_port_out), .display_seg_pin(display_seg_pin),
  .display_seg_out(display_seg_out), .remote_timer_in(remote_timer_in),
  .conv_channel(conv_channel), .serial_b_clock_in(serial_b_clock_in),
  .serial_a_data_in(serial_a_data_in), .serial_a_clock_in(serial_a_clock_in),
  .event_counter_in(event_counter_in)
);

/* File: dv/ppm_board.sv */
`timescale 1ns/10ps
module ppm_board (
  input wire logic pclk,
  input wire ppm_pkg::ppm_byte_t out,
  input wire ppm_pkg::ppm_byte_t oe_n,
  input wire ppm_pkg::ppm_byte_t pu,
  input wire ppm_pkg::ppm_byte_t ext,
  input wire ppm_pkg::ppm_byte_t ext_en,
  output ppm_pkg::ppm_byte_t pin
);
  import ppm_pkg::*;
  ppm_byte_t drift = 8'h55;

  // Floating pads wander every cycle
  always_ff @(posedge pclk) begin
    drift <= ~drift;
  end

  // Pad level: chip drive, then board drive, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n[i]) pin[i] = out[i];
      else if (ext_en[i]) pin[i] = ext[i];
      else if (pu[i]) pin[i] = 1'b1;
      else pin[i] = drift[i];
    end
  end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`include "ppm_consts.svh"
module tb_top;
  import ppm_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [7:0] paddr, per;
  logic [31:0] pwdata, prdata, rdat;
  ppm_byte_t fp_in, fp_out, fp_oe_n, fp_pu, sp_in, sp_out, sp_oe_n, sp_pu, fp_ext;
  ppm_byte_t p3_out, p3_oe_n, p4_out, p4_oe_n, p5_in, p5_out, p5_oe_n;
  logic [4:0] p6_in, p6_out, p6_oe_n;
  logic [23:0] seg_pin;
  logic [52:0] seg;
  int n_fail, tests_run;

  always #20 pclk = ~pclk;
  // Released open-drain pads sit on the pull-down
  assign p5_in = ~p5_oe_n;
  assign p6_in = ~p6_oe_n;

  ppm_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .first_port_in(fp_in), .first_port_out(fp_out), .first_port_oe_n(fp_oe_n),
    .first_port_pullup(fp_pu), .second_port_in(sp_in), .second_port_out(sp_out),
    .second_port_oe_n(sp_oe_n), .second_port_pullup(sp_pu), .third_port_out(p3_out),
    .third_port_oe_n(p3_oe_n), .fourth_port_out(p4_out), .fourth_port_oe_n(p4_oe_n),
    .fifth_port_in(p5_in), .fifth_port_out(p5_out), .fifth_port_oe_n(p5_oe_n),
    .sixth_port_in(p6_in), .sixth_port_out(p6_out), .sixth_port_oe_n(p6_oe_n),
    .display_seg_pin(seg_pin), .display_seg_out(seg), .buzzer_out(per[0]),
    .serial_b_clock_out(per[1]), .serial_b_clock_oe(per[2]), .serial_b_data_out(per[3]),
    .serial_a_data_out(per[4]), .serial_a_clock_out(per[5]), .serial_a_clock_oe(per[6]),
    .pwm_out(per[7]), .remote_timer_in(), .conv_channel(), .serial_b_clock_in(),
    .serial_a_data_in(), .serial_a_clock_in(), .event_counter_in());
  ppm_board u_fp (.pclk(pclk), .out(fp_out), .oe_n(fp_oe_n), .pu(fp_pu), .ext(fp_ext),
    .ext_en(8'h83), .pin(fp_in));
  ppm_board u_sp (.pclk(pclk), .out(sp_out), .oe_n(sp_oe_n), .pu(sp_pu), .ext(8'h00),
    .ext_en(8'h00), .pin(sp_in));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus transfer, held until the answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic t_reset;
    chk("fp oe_n", fp_oe_n, 8'hff);
    chk("fp pullup", fp_pu, 8'h00);
    chk("p3 oe_n", p3_oe_n, 8'hff);
    for (int a = 0; a <= 'h4c; a += 4) begin
      if (a != 'h40) begin
        apb(1'b0, 8'(a), 32'h0);
        chk("reset reg", rdat, 32'h0);
      end
    end
    $display("test reset done");
  endtask

  task automatic t_bidir;
    apb(1'b1, `PPM_OFS_FP_DATA, 32'ha5);
    apb(1'b1, `PPM_OFS_FP_DIR, 32'h0f);
    apb(1'b1, `PPM_OFS_FP_PULL, 32'h7f);
    apb(1'b1, `PPM_OFS_SP_DATA, 32'h3c);
    apb(1'b1, `PPM_OFS_SP_DIR, 32'hf0);
    apb(1'b1, `PPM_OFS_SP_PULL, 32'hff);
    settle(2);
    chk("fp oe_n", fp_oe_n, 8'hf0);
    chk("fp out", fp_out & 8'h0f, 8'h05);
    chk("fp pullup", fp_pu, 8'h70);
    chk("sp oe_n", sp_oe_n, 8'h0f);
    chk("sp out", sp_out & 8'hf0, 8'h30);
    chk("sp pullup", sp_pu, 8'h0f);
    apb(1'b0, `PPM_OFS_PIN_LEVEL, 32'h0);
    chk("pin levels", rdat[15:0], 16'h3f75);
    apb(1'b1, `PPM_OFS_FP_DIR, 32'h0);
    apb(1'b1, `PPM_OFS_SP_DIR, 32'h0);
    $display("test bidir done");
  endtask

  task automatic t_alt;
    per <= 8'h17;
    apb(1'b1, `PPM_OFS_FP_ALT, 32'h80);
    apb(1'b1, `PPM_OFS_SP_ALT, 32'h23);
    settle(2);
    chk("fp oe_n alt", fp_oe_n, 8'h7f);
    chk("fp buzzer", fp_out[7], 1'b1);
    chk("sp oe_n alt", sp_oe_n, 8'hdc);
    chk("sp out alt", sp_out & 8'h23, 8'h21);
    @(posedge pclk) per <= 8'h02;
    settle(2);
    chk("fp buzzer low", fp_out[7], 1'b0);
    chk("sp clock off", sp_oe_n, 8'hdd);
    chk("sp out low", sp_out & 8'h22, 8'h00);
    $display("test alternate done");
  endtask

  task automatic t_od;
    @(posedge pclk) seg <= {5'h05, 24'ha5a5a5, 24'h5a3c96};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `PPM_OFS_P3_DATA + 8'(i * 8), 32'h3c);
      apb(1'b1, `PPM_OFS_P3_ALT + 8'(i * 8), 32'h0f);
    end
    settle(2);
    chk("p3 oe_n", p3_oe_n, 8'hca);
    chk("p4 oe_n", p4_oe_n, 8'hca);
    chk("p5 oe_n", p5_oe_n, 8'hca);
    chk("p6 oe_n", p6_oe_n, 5'h0a);
    chk("p3 out", p3_out, 8'hff);
    chk("seg pins", seg_pin, 24'h5a3c96);
    @(posedge pclk) per <= 8'h80;
    apb(1'b1, `PPM_OFS_P6_ALT, 32'h1f);
    apb(1'b1, `PPM_OFS_EDGE_CFG, 32'h10);
    settle(2);
    chk("pwm high", p6_oe_n, 5'h0a);
    @(posedge pclk) per <= 8'h00;
    settle(2);
    chk("pwm low", p6_oe_n, 5'h1a);
    $display("test open drain done");
  endtask

  task automatic t_irq;
    logic exp;
    apb(1'b1, `PPM_OFS_FP_ALT, 32'h83);
    apb(1'b1, `PPM_OFS_IRQ_MASK, 32'h3);
    for (int j = 0; j < 2; j++) begin
      for (int m = 0; m < 4; m++) begin
        apb(1'b1, `PPM_OFS_EDGE_CFG, 32'(m << (2 * j)));
        apb(1'b1, `PPM_OFS_IRQ_STATUS, 32'h3);
        fp_ext[j] <= 1'b1;
        settle(4);
        exp = (m == 0) || (m == 2);
        apb(1'b0, `PPM_OFS_IRQ_STATUS, 32'h0);
        chk("rise status", rdat, 32'(exp) << j);
        chk("rise irq", irq, exp);
        apb(1'b1, `PPM_OFS_IRQ_STATUS, 32'h3);
        fp_ext[j] <= 1'b0;
        settle(4);
        exp = (m == 1) || (m == 2);
        apb(1'b0, `PPM_OFS_IRQ_STATUS, 32'h0);
        chk("fall status", rdat, 32'(exp) << j);
        apb(1'b1, `PPM_OFS_IRQ_STATUS, 32'h3);
      end
    end
    apb(1'b1, `PPM_OFS_IRQ_MASK, 32'h0);
    apb(1'b1, `PPM_OFS_EDGE_CFG, 32'h0);
    fp_ext[0] <= 1'b1;
    settle(4);
    chk("masked irq", irq, 1'b0);
    apb(1'b1, `PPM_OFS_IRQ_MASK, 32'h1);
    settle(2);
    chk("unmasked irq", irq, 1'b1);
    apb(1'b1, `PPM_OFS_IRQ_STATUS, 32'h1);
    settle(2);
    chk("cleared irq", irq, 1'b0);
    $display("test interrupt done");
  endtask

  task automatic t_err;
    apb(1'b1, 8'h50, 32'hff);
    chk("unmapped write", rerr, 1'b1);
    apb(1'b0, 8'h50, 32'h0);
    chk("unmapped read err", rerr, 1'b1);
    chk("unmapped read", rdat, 32'h0);
    $display("test unmapped done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    per = 8'h00;
    seg = '0;
    fp_ext = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    t_reset;
    t_bidir;
    t_alt;
    t_od;
    t_irq;
    t_err;
    give_verdict;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("watchdog expired");
    give_verdict;
  end
endmodule
